//--- hdl/dual_byte_gpio_ports.sv
// Two byte-wide I/O ports with the second port's alternate-function selection.
//
// Contract
// - two 8-bit ports, each pin independently directed
// - direction bit 1 output, 0 input
// - direction registers clear on reset
// - direction registers are write-only
// - output pins drive the written data
// - input pins read the sampled level
// - data latch is not reset
// - open-drain bit 1 open drain, 0 push-pull
// - open-drain registers write-only, clear on reset
// - pull-up control 0 enables, 1 disables
// - pull-up off on output pins
// - pull-up registers write-only, clear on reset
// - mode bit selects port or alternate function
// - mode register write-only, clears on reset
// - plain I/O only while mode bit 0, except pins 0 and 3, which have no function and stay plain I/O
`timescale 1ns/1ps
module dual_byte_gpio_ports
  import gpio_pkg::*;
#(
  parameter int W = PORT_W
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata,
  input  wire logic         timer_a_output,
  input  wire logic         timer_b_output,
  input  wire logic         timer_c_output,
  input  wire logic [W-1:0] port_a_pin_in,
  output logic      [W-1:0] port_a_pin_out,
  output logic      [W-1:0] port_a_pin_oe,
  output logic      [W-1:0] port_a_pullup_en,
  input  wire logic [W-1:0] port_b_pin_in,
  output logic      [W-1:0] port_b_pin_out,
  output logic      [W-1:0] port_b_pin_oe,
  output logic      [W-1:0] port_b_pullup_en,
  output logic              timer_a_event_input,
  output logic              ext_irq_one_input,
  output logic              ext_irq_two_capture_input
);

  typedef struct packed {
    logic [W-1:0] mode;
    logic [7:0]   rdata;
    logic         evt;
    logic         irq_one;
    logic         irq_two;
  } top_state_type;

  top_state_type st_r;
  top_state_type st_nxt;
  logic [W-1:0]  mode_eff;
  logic [W-1:0]  timer_bus;

  pin_bank_if #(.W(W)) bus_a ();
  pin_bank_if #(.W(W)) bus_b ();

  // Each port is the same bank; the first port simply has no alternate functions.
  pin_bank #(
    .W (W)
  ) bank_a (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .ctl       (bus_a.bank),
    .pin_in    (port_a_pin_in),
    .pin_out   (port_a_pin_out),
    .pin_oe    (port_a_pin_oe),
    .pullup_en (port_a_pullup_en)
  );

  pin_bank #(
    .W (W)
  ) bank_b (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .ctl       (bus_b.bank),
    .pin_in    (port_b_pin_in),
    .pin_out   (port_b_pin_out),
    .pin_oe    (port_b_pin_oe),
    .pullup_en (port_b_pullup_en)
  );

  // Mode bits with no function behind them are ignored, so those pins stay plain I/O.
  always_comb begin
    mode_eff                 = st_r.mode & (ALT_OUT_MASK | ALT_IN_MASK);
    timer_bus                = '0;
    timer_bus[SEL_TIMER_A]   = timer_a_output;
    timer_bus[SEL_TIMER_B]   = timer_b_output;
    timer_bus[SEL_TIMER_C]   = timer_c_output;
  end

  // Alternate-function steering towards the second bank.
  assign bus_a.alt_drive = '0;
  assign bus_a.alt_value = '0;
  assign bus_a.alt_input = '0;
  assign bus_b.alt_drive = mode_eff & ALT_OUT_MASK;
  assign bus_b.alt_value = timer_bus;
  assign bus_b.alt_input = mode_eff & ALT_IN_MASK;
  assign bus_a.wdata     = reg_wdata;
  assign bus_b.wdata     = reg_wdata;

  // Write decode; every write stores the whole byte, as software never does partial updates.
  always_comb begin
    bus_a.wr_data = 1'b0;
    bus_a.wr_dir  = 1'b0;
    bus_a.wr_od   = 1'b0;
    bus_a.wr_pud  = 1'b0;
    bus_b.wr_data = 1'b0;
    bus_b.wr_dir  = 1'b0;
    bus_b.wr_od   = 1'b0;
    bus_b.wr_pud  = 1'b0;
    if (!reg_wr) begin
      bus_a.wr_data = 1'b0;
    end else if (reg_addr == ADDR_A_DATA) begin
      bus_a.wr_data = 1'b1;
    end else if (reg_addr == ADDR_A_DIR) begin
      bus_a.wr_dir = 1'b1;
    end else if (reg_addr == ADDR_A_OD) begin
      bus_a.wr_od = 1'b1;
    end else if (reg_addr == ADDR_A_PUD) begin
      bus_a.wr_pud = 1'b1;
    end else if (reg_addr == ADDR_B_DATA) begin
      bus_b.wr_data = 1'b1;
    end else if (reg_addr == ADDR_B_DIR) begin
      bus_b.wr_dir = 1'b1;
    end else if (reg_addr == ADDR_B_OD) begin
      bus_b.wr_od = 1'b1;
    end else if (reg_addr == ADDR_B_PUD) begin
      bus_b.wr_pud = 1'b1;
    end
  end

  // Mode write, read mux and the listening alternate-function outputs.
  always_comb begin
    st_nxt = st_r;
    if (reg_wr && (reg_addr == ADDR_B_MODE)) begin
      st_nxt.mode = reg_wdata;
    end
    if (reg_rd) begin
      // Write-only and unmapped addresses read as zero rather than stale data.
      if (reg_addr == ADDR_A_DATA) begin
        st_nxt.rdata = bus_a.rd_value;
      end else if (reg_addr == ADDR_B_DATA) begin
        st_nxt.rdata = bus_b.rd_value;
      end else begin
        st_nxt.rdata = READ_EMPTY;
      end
    end
    st_nxt.evt     = mode_eff[SEL_EVENT] & port_b_pin_in[SEL_EVENT];
    st_nxt.irq_one = mode_eff[SEL_IRQ_ONE] & port_b_pin_in[SEL_IRQ_ONE];
    st_nxt.irq_two = mode_eff[SEL_IRQ_TWO] & port_b_pin_in[SEL_IRQ_TWO];
  end

  // Single state register of the decoder.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r.mode    <= CTRL_RESET;
      st_r.rdata   <= READ_EMPTY;
      st_r.evt     <= 1'b0;
      st_r.irq_one <= 1'b0;
      st_r.irq_two <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata                 = st_r.rdata;
  assign timer_a_event_input       = st_r.evt;
  assign ext_irq_one_input         = st_r.irq_one;
  assign ext_irq_two_capture_input = st_r.irq_two;

  // Shadow copies of write-only registers, kept only for the checks below.
  logic [W-1:0] chk_dir_a;
  logic [W-1:0] chk_od_a;
  logic [W-1:0] chk_od_b;
  logic [W-1:0] chk_mode_b;
  logic [W-1:0] chk_dir_b;
  logic [W-1:0] chk_pud_a;
  logic [W-1:0] chk_pud_b;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      chk_dir_a  <= '0;
      chk_od_a   <= '0;
      chk_od_b   <= '0;
      chk_mode_b <= '0;
      chk_dir_b  <= '0;
      chk_pud_a  <= '0;
      chk_pud_b  <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_A_DIR) begin
        chk_dir_a <= reg_wdata;
      end
      if (reg_addr == ADDR_A_OD) begin
        chk_od_a <= reg_wdata;
      end
      if (reg_addr == ADDR_B_OD) begin
        chk_od_b <= reg_wdata;
      end
      if (reg_addr == ADDR_B_MODE) begin
        chk_mode_b <= reg_wdata;
      end
      if (reg_addr == ADDR_B_DIR) begin
        chk_dir_b <= reg_wdata;
      end
      if (reg_addr == ADDR_A_PUD) begin
        chk_pud_a <= reg_wdata;
      end
      if (reg_addr == ADDR_B_PUD) begin
        chk_pud_b <= reg_wdata;
      end
    end
  end

  // After reset all pins are undriven inputs with pull-ups on and no function routed.
  a_reset_inputs: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(rstn) |-> (port_a_pin_oe == 8'h00) && (port_b_pin_oe == 8'h00)
      && (port_a_pullup_en == 8'hFF) && (port_b_pullup_en == 8'hFF)
      && !ext_irq_one_input && !ext_irq_two_capture_input && !timer_a_event_input)
    else $error("Ports not idle inputs after reset.");

  // A pin never pulls up while it drives.
  a_pull_off_drive: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ((port_a_pullup_en & port_a_pin_oe) == 8'h00)
      && ((port_b_pullup_en & port_b_pin_oe) == 8'h00))
    else $error("Pull-up active on a driving pin.");

  // Every first-port pull-up control bit that is set has removed its pull-up two cycles on.
  a_pull_disable: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_wr && reg_addr == ADDR_A_PUD) ##1 !reg_wr
      |=> (port_a_pullup_en & $past(reg_wdata, 2)) == 8'h00)
    else $error("Pull-up stayed on after disable.");

  // The first port has no functions, so its pull-up is exactly input and enabled.
  a_pull_follows_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    port_a_pullup_en == (~$past(chk_dir_a) & ~$past(chk_pud_a)))
    else $error("Port A pull-up does not follow its control.");

  // Second-port pins that nothing drives pull up unless their control bit says otherwise.
  a_pull_follows_b: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ((port_b_pullup_en ^ ~$past(chk_pud_b))
      & ~$past(chk_dir_b) & ~($past(chk_mode_b) & ALT_OUT_MASK)) == 8'h00)
    else $error("Port B pull-up does not follow its control.");

  // Only a set direction bit, or a routed timer output, ever enables a pin driver.
  a_no_stray_drive: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ((port_a_pin_oe & ~$past(chk_dir_a)) == 8'h00)
      && ((port_b_pin_oe
        & ~($past(chk_dir_b) | ($past(chk_mode_b) & ALT_OUT_MASK))) == 8'h00))
    else $error("Pin driven without direction or timer.");

  // A pin handed to a listening function is never driven, whatever its direction bit.
  a_listen_undriven: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (port_b_pin_oe & $past(chk_mode_b) & ALT_IN_MASK) == 8'h00)
    else $error("Listening pin is driven.");

  // An open-drain pin may only sink, so its drive level is never high.
  a_od_never_high: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ((port_a_pin_out & $past(chk_od_a)) == 8'h00)
      && ((port_b_pin_out & $past(chk_od_b)) == 8'h00))
    else $error("Open-drain pin driven high.");

  // Write-only and unmapped registers read back as zero.
  a_wo_read_zero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_rd && reg_addr != ADDR_A_DATA && reg_addr != ADDR_B_DATA)
      |=> reg_rdata == READ_EMPTY)
    else $error("Write-only register returned data.");

  // Read data stands until the next read.
  a_rdata_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read.");

  // Input pins read the level present in the cycle of the read.
  a_read_pins: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_rd && reg_addr == ADDR_A_DATA)
      |=> ((reg_rdata ^ $past(port_a_pin_in)) & ~$past(chk_dir_a)) == 8'h00)
    else $error("Input pin read returned wrong level.");

  // Second-port inputs and function pins read the live level.
  a_read_pins_b: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_rd && reg_addr == ADDR_B_DATA)
      |=> ((reg_rdata ^ $past(port_b_pin_in))
        & (~$past(chk_dir_b) | ($past(chk_mode_b) & (ALT_OUT_MASK | ALT_IN_MASK)))) == 8'h00)
    else $error("Port B pin read returned wrong level.");

  // Push-pull outputs show the written byte two cycles after the write.
  a_drive_data: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_wr && reg_addr == ADDR_A_DATA) ##1 !reg_wr
      |=> (((port_a_pin_out ^ $past(reg_wdata, 2)) & $past(chk_dir_a) & ~$past(chk_od_a))
        == 8'h00)
      && (((port_a_pin_oe ^ $past(chk_dir_a)) & ~$past(chk_od_a)) == 8'h00))
    else $error("Output pins do not carry written data.");

  // Open-drain pins only ever pull low.
  a_open_drain: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_wr && reg_addr == ADDR_A_OD && reg_wdata == 8'hFF) ##1 !reg_wr
      |=> port_a_pin_out == 8'h00)
    else $error("Open-drain pin drove high.");

  // Timer output takes the pin once selected.
  a_timer_route: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_wr && reg_addr == ADDR_B_MODE && reg_wdata[SEL_TIMER_A] && !chk_od_b[SEL_TIMER_A])
      ##1 !reg_wr
      |=> port_b_pin_oe[SEL_TIMER_A]
        && (port_b_pin_out[SEL_TIMER_A] == $past(timer_a_output)))
    else $error("Timer output not routed to pin.");

  // The other two timer outputs take their pins the same way.
  a_timer_bc_route: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (reg_wr && reg_addr == ADDR_B_MODE && reg_wdata[SEL_TIMER_B] && reg_wdata[SEL_TIMER_C]
      && !chk_od_b[SEL_TIMER_B] && !chk_od_b[SEL_TIMER_C]) ##1 !reg_wr
      |=> port_b_pin_oe[SEL_TIMER_B] && port_b_pin_oe[SEL_TIMER_C]
        && (port_b_pin_out[SEL_TIMER_B] == $past(timer_b_output))
        && (port_b_pin_out[SEL_TIMER_C] == $past(timer_c_output)))
    else $error("Timer output not routed to pin.");

  // Interrupt input stays quiet unless its pin is switched to the function.
  a_irq_gate: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ext_irq_one_input |-> $past(chk_mode_b[SEL_IRQ_ONE]) && $past(port_b_pin_in[SEL_IRQ_ONE]))
    else $error("Interrupt input passed in port mode.");

  // The capture input is gated the same way.
  a_irq_two_gate: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ext_irq_two_capture_input
      |-> $past(chk_mode_b[SEL_IRQ_TWO]) && $past(port_b_pin_in[SEL_IRQ_TWO]))
    else $error("Capture input passed in port mode.");

  // The timer event input only follows its pin when the function is selected.
  a_event_gate: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    timer_a_event_input |-> $past(chk_mode_b[SEL_EVENT]) && $past(port_b_pin_in[SEL_EVENT]))
    else $error("Event input passed in port mode.");

endmodule : dual_byte_gpio_ports

//--- hdl/pin_bank.sv
// One port: direction, data, open-drain and pull-up registers plus pin drivers.
`timescale 1ns/1ps
module pin_bank
  import gpio_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  pin_bank_if.bank          ctl,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pullup_en
);

  typedef struct packed {
    logic [W-1:0] dir;
    logic [W-1:0] data;
    logic [W-1:0] od;
    logic [W-1:0] pud;
    logic [W-1:0] out;
    logic [W-1:0] oe;
    logic [W-1:0] pull;
  } bank_state_type;

  bank_state_type st_r;
  bank_state_type st_nxt;
  logic [W-1:0]   drive_en;
  logic [W-1:0]   drive_val;

  // Register writes and the pin driver terms; drivers are registered so outputs are glitch free.
  always_comb begin
    st_nxt = st_r;
    if (ctl.wr_dir) begin
      st_nxt.dir = ctl.wdata;
    end
    if (ctl.wr_data) begin
      st_nxt.data = ctl.wdata;
    end
    if (ctl.wr_od) begin
      st_nxt.od = ctl.wdata;
    end
    if (ctl.wr_pud) begin
      st_nxt.pud = ctl.wdata;
    end
    // A timer output owns its pin; a listening function forces the pin to input.
    drive_en     = ctl.alt_drive | (st_r.dir & ~ctl.alt_input);
    drive_val    = (ctl.alt_drive & ctl.alt_value) | (~ctl.alt_drive & st_r.data);
    st_nxt.oe    = drive_en & (~st_r.od | ~drive_val);
    st_nxt.out   = drive_en & ~st_r.od & drive_val;
    st_nxt.pull  = ~drive_en & ~st_r.pud;
  end

  // Port-driven pins read back the latch; inputs and timer-driven pins read the live level.
  assign ctl.rd_value = (drive_en & ~ctl.alt_drive & st_r.data)
                      | ((~drive_en | ctl.alt_drive) & pin_in);

  // The data latch is deliberately left out of reset, so its content is unknown until written.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r.dir  <= '0;
      st_r.od   <= '0;
      st_r.pud  <= '0;
      st_r.out  <= '0;
      st_r.oe   <= '0;
      st_r.pull <= PULL_RESET;
    end else begin
      st_r <= st_nxt;
    end
    st_r.data <= st_nxt.data;
  end

  assign pin_out   = st_r.out;
  assign pin_oe    = st_r.oe;
  assign pullup_en = st_r.pull;

endmodule : pin_bank

//--- pkg/gpio_pkg.sv
// Shared constants for the two byte-wide general-purpose I/O ports.
package gpio_pkg;

  // Width of each port in pins.
  localparam int PORT_W = 8;

  // Control-register addresses in the processor's control space.
  localparam logic [7:0] ADDR_A_DATA = 8'hC0;
  localparam logic [7:0] ADDR_A_DIR  = 8'hC1;
  localparam logic [7:0] ADDR_B_DATA = 8'hC2;
  localparam logic [7:0] ADDR_B_DIR  = 8'hC3;
  localparam logic [7:0] ADDR_B_MODE = 8'hC9;
  localparam logic [7:0] ADDR_B_OD   = 8'hDE;
  localparam logic [7:0] ADDR_A_OD   = 8'hE4;
  localparam logic [7:0] ADDR_A_PUD  = 8'hF8;
  localparam logic [7:0] ADDR_B_PUD  = 8'hF9;

  // Value every control register except the data latches takes on reset, and what write-only reads return.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_EMPTY = 8'h00;

  // Pull-up drive on reset: every pin starts as an input with its pull-up on.
  localparam logic [7:0] PULL_RESET = 8'hFF;

  // Bit positions of the alternate functions in the second port's mode register.
  localparam int SEL_TIMER_A = 7;
  localparam int SEL_TIMER_B = 6;
  localparam int SEL_TIMER_C = 5;
  localparam int SEL_EVENT   = 4;
  localparam int SEL_IRQ_TWO = 2;
  localparam int SEL_IRQ_ONE = 1;

  // Pins whose alternate function drives them, and pins whose function listens.
  localparam logic [7:0] ALT_OUT_MASK = 8'hE0;
  localparam logic [7:0] ALT_IN_MASK  = 8'h16;

endpackage : gpio_pkg

//--- pkg/pin_bank_if.sv
// Control path between the register decoder and one port's pin bank.
`timescale 1ns/1ps
interface pin_bank_if #(
  parameter int W = 8
);
  logic         wr_data;
  logic         wr_dir;
  logic         wr_od;
  logic         wr_pud;
  logic [W-1:0] wdata;
  logic [W-1:0] alt_drive;
  logic [W-1:0] alt_value;
  logic [W-1:0] alt_input;
  logic [W-1:0] rd_value;

  modport bank (input wr_data, wr_dir, wr_od, wr_pud, wdata,
                input alt_drive, alt_value, alt_input, output rd_value);
  modport ctrl (output wr_data, wr_dir, wr_od, wr_pud, wdata,
                output alt_drive, alt_value, alt_input, input rd_value);
endinterface : pin_bank_if

//--- test/dual_byte_gpio_ports_test.sv
// Self-checking testbench for the two byte-wide I/O ports.
`timescale 1ns/1ps
module dual_byte_gpio_ports_test
  import gpio_pkg::*;
;
  logic       sys_clk, rstn, reg_wr, reg_rd, tmr_a, tmr_b, tmr_c, ev_out, irq1, irq2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [7:0] a_in, a_out, a_oe, a_pu, a_ev, a_en;
  logic [7:0] b_in, b_out, b_oe, b_pu, b_ev, b_en;
  int         n_errors = 0;
  int         n_checks = 0;
  int         cycles = 0;
  logic [7:0] wo_list [8] = '{8'hC1, 8'hC3, 8'hC9, 8'hDE, 8'hE4, 8'hF8, 8'hF9, 8'hD0};

  dual_byte_gpio_ports dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_a_output(tmr_a),
    .timer_b_output(tmr_b), .timer_c_output(tmr_c), .port_a_pin_in(a_in),
    .port_a_pin_out(a_out), .port_a_pin_oe(a_oe), .port_a_pullup_en(a_pu),
    .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe(b_oe),
    .port_b_pullup_en(b_pu), .timer_a_event_input(ev_out), .ext_irq_one_input(irq1),
    .ext_irq_two_capture_input(irq2));
  pin_board_model board_a (.pin_out(a_out), .pin_oe(a_oe), .pullup_en(a_pu), .ext_val(a_ev),
    .ext_en(a_en), .sys_clk(sys_clk), .pin_in(a_in));
  pin_board_model board_b (.pin_out(b_out), .pin_oe(b_oe), .pullup_en(b_pu), .ext_val(b_ev),
    .ext_en(b_en), .sys_clk(sys_clk), .pin_in(b_in));

  // Clock at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // The whole run needs about 130 cycles; the ceiling leaves wide margin.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Whole-byte write; the strobe is dropped a cycle before any following access.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    check(reg_rdata, exp);
  endtask : rdchk

  task automatic ext(input logic [7:0] av, ae, bv, be);
    @(posedge sys_clk);
    a_ev <= av;
    a_en <= ae;
    b_ev <= bv;
    b_en <= be;
  endtask : ext

  task automatic tmr(input logic a, b, c);
    @(posedge sys_clk);
    tmr_a <= a;
    tmr_b <= b;
    tmr_c <= c;
  endtask : tmr

  // Pin effects land two edges after a write; three leave margin.
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic reset_ports;
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
  endtask : reset_ports

  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    {tmr_a, tmr_b, tmr_c} = 3'h0;
    a_ev = 8'hA5;
    a_en = 8'hFF;
    b_ev = 8'h00;
    b_en = 8'h00;
    reset_ports();
    check(a_oe, 8'h00);
    check(b_oe, 8'h00);
    check(a_pu, 8'hFF);
    check(b_pu, 8'hFF);
    check({5'h00, ev_out, irq2, irq1}, 8'h00);
    rdchk(ADDR_A_DATA, 8'hA5);
    $display("Test reset state done");
    ext(8'h05, 8'h0F, 8'h00, 8'h00);
    wr(ADDR_A_DATA, 8'h3C);
    wr(ADDR_A_DIR, 8'hF0);
    settle();
    check(a_oe, 8'hF0);
    check(a_out & a_oe, 8'h30);
    check(a_pu, 8'h0F);
    rdchk(ADDR_A_DATA, 8'h35);
    wr(ADDR_A_PUD, 8'h03);
    settle();
    check(a_pu, 8'h0C);
    wr(ADDR_A_OD, 8'hFF);
    settle();
    check(a_oe, 8'hC0);
    check(a_out & a_oe, 8'h00);
    wr(ADDR_A_OD, 8'h00);
    wr(ADDR_A_DATA, 8'hC3);
    settle();
    check(a_out, 8'hC0);
    check(a_oe, 8'hF0);
    $display("Test port A drive done");
    wr(ADDR_B_DATA, 8'h0F);
    wr(ADDR_B_DIR, 8'hFF);
    settle();
    check(b_out, 8'h0F);
    tmr(1'b1, 1'b0, 1'b1);
    wr(ADDR_B_MODE, 8'hE0);
    settle();
    check(b_out, 8'hAF);
    tmr(1'b0, 1'b1, 1'b1);
    settle();
    check(b_out, 8'h6F);
    rdchk(ADDR_B_DATA, 8'h6F);
    ext(8'h05, 8'h0F, 8'h12, 8'h16);
    wr(ADDR_B_MODE, 8'h16);
    settle();
    check(b_oe, 8'hE9);
    check({5'h00, ev_out, irq2, irq1}, 8'h05);
    rdchk(ADDR_B_DATA, 8'h1B);
    ext(8'h05, 8'h0F, 8'h04, 8'h16);
    settle();
    check({5'h00, ev_out, irq2, irq1}, 8'h02);
    $display("Test port B functions done");
    wr(8'hD0, 8'hFF);
    foreach (wo_list[i]) begin
      rdchk(wo_list[i], READ_EMPTY);
    end
    check(b_oe, 8'hE9);
    $display("Test write-only reads done");
    ext(8'h05, 8'h0F, 8'h00, 8'h00);
    reset_ports();
    check(a_oe, 8'h00);
    check(b_pu, 8'hFF);
    check({5'h00, ev_out, irq2, irq1}, 8'h00);
    wr(ADDR_B_DIR, 8'hFF);
    settle();
    check(b_out, 8'h0F);
    $display("Test second reset done");
    print_verdict();
  end
endmodule : dual_byte_gpio_ports_test

//--- test/pin_board_model.sv
// Board-side model of eight port pins: outside drivers, pull-ups and floating lines.
`timescale 1ns/1ps
module pin_board_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic       sys_clk,
  output logic      [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;

  // A line that nobody holds shows the inverse of its last level, so a float never reads right by luck.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_r[i];
    end
  end

  // Remember the level of each line for the float pattern.
  always_ff @(posedge sys_clk) begin
    last_r <= pin_in;
  end
endmodule : pin_board_model
